//--- hdl/mlb_pkg.sv
package mlb_pkg;

   // -------------------------------------------------------------------
   // Widths and capacity
   // -------------------------------------------------------------------
   localparam int unsigned CAP    = 100000;
   localparam int unsigned REC_W  = 32;
   localparam int unsigned CNT_W  = 17;
   localparam int unsigned ADDR_W = 4;
   localparam int unsigned DATA_W = 32;

   // -------------------------------------------------------------------
   // Register word offsets
   // -------------------------------------------------------------------
   localparam logic [3:0] OFS_MODE     = 4'h0;
   localparam logic [3:0] OFS_DEPTH    = 4'h1;
   localparam logic [3:0] OFS_POST     = 4'h2;
   localparam logic [3:0] OFS_EVENT    = 4'h3;
   localparam logic [3:0] OFS_CTRL     = 4'h4;
   localparam logic [3:0] OFS_POP_CNT  = 4'h5;
   localparam logic [3:0] OFS_POP_DATA = 4'h6;
   localparam logic [3:0] OFS_LAST     = 4'h7;
   localparam logic [3:0] OFS_POINTS   = 4'h8;
   localparam logic [3:0] OFS_STATE    = 4'h9;
   localparam logic [3:0] OFS_RECORDED = 4'ha;
   localparam logic [3:0] OFS_REMAIN   = 4'hb;
   localparam logic [3:0] OFS_ERR      = 4'hc;

   // -------------------------------------------------------------------
   // Field positions
   // -------------------------------------------------------------------
   localparam int unsigned CTRL_INIT_BIT  = 0;
   localparam int unsigned CTRL_READ_BIT  = 1;
   localparam int unsigned CTRL_ABORT_BIT = 2;
   localparam int unsigned CTRL_CLEAR_BIT = 3;
   localparam int unsigned ERR_BIT        = 0;

   // -------------------------------------------------------------------
   // Codes, limits and reset values
   // -------------------------------------------------------------------
   localparam logic       MODE_NORMAL = 1'h0;
   localparam logic       MODE_BULK   = 1'h1;
   localparam logic [1:0] EVT_NONE    = 2'h0;
   localparam logic [1:0] EVT_EXT     = 2'h1;
   localparam logic [1:0] EVT_LEVEL   = 2'h2;
   localparam logic [1:0] EVT_LIMIT   = 2'h3;

   localparam logic [31:0] DEPTH_1K   = 32'h000003e8;
   localparam logic [31:0] DEPTH_2K   = 32'h000007d0;
   localparam logic [31:0] DEPTH_5K   = 32'h00001388;
   localparam logic [31:0] DEPTH_10K  = 32'h00002710;
   localparam logic [31:0] DEPTH_20K  = 32'h00004e20;
   localparam logic [31:0] DEPTH_50K  = 32'h0000c350;
   localparam logic [31:0] DEPTH_100K = 32'h000186a0;
   localparam logic [31:0] POST_MAX   = 32'h00000064;
   localparam logic [31:0] POP_MIN    = 32'h00000001;
   localparam logic [31:0] POP_MAX    = 32'h000186a0;
   localparam logic [23:0] PCT_FULL   = 24'h000064;

   localparam logic [16:0] RST_DEPTH  = 17'h003e8;
   localparam logic [6:0]  RST_POST   = 7'h32;
   localparam logic [31:0] NAN_CODE   = 32'h7f7fffff;

   typedef enum logic [1:0] {
      MLB_ST_STOP,
      MLB_ST_WAIT,
      MLB_ST_POST
   } mlb_bulk_type;

   // Clamp to [lo, hi]; used for depth, post share and removal count
   function automatic logic [31:0] clamp(input logic [31:0] v,
                                         input logic [31:0] lo,
                                         input logic [31:0] hi);
      if (v < lo) begin
         return lo;
      end
      if (v > hi) begin
         return hi;
      end
      return v;
   endfunction : clamp

endpackage : mlb_pkg

//--- hdl/mlb_log_mem.sv
`timescale 1ns/1ps
module mlb_log_mem (
   input  wire logic                    clk_sys_in,
   input  wire logic                    nrst_in,
   input  wire logic                    clr_in,
   input  wire logic                    push_in,
   input  wire logic [mlb_pkg::REC_W-1:0] push_data_in,
   input  wire logic                    pop_in,
   output logic      [mlb_pkg::REC_W-1:0] oldest_out,
   output logic      [mlb_pkg::REC_W-1:0] newest_out,
   output logic      [mlb_pkg::CNT_W-1:0] count_out
);

   // -------------------------------------------------------------------
   // Storage and pointers
   // -------------------------------------------------------------------
   logic [mlb_pkg::REC_W-1:0] mem_q [0:mlb_pkg::CAP-1];
   logic [mlb_pkg::CNT_W-1:0] head_q;
   logic [mlb_pkg::CNT_W-1:0] tail_q;
   logic [mlb_pkg::CNT_W-1:0] count_q;
   logic [mlb_pkg::CNT_W-1:0] prev_tail;

   // Ring wrap; capacity is not a power of two
   function automatic logic [mlb_pkg::CNT_W-1:0] next_idx(
      input logic [mlb_pkg::CNT_W-1:0] i);
      if (i == mlb_pkg::CNT_W'(mlb_pkg::CAP - 1)) begin
         return '0;
      end
      return mlb_pkg::CNT_W'(i + 1'b1);
   endfunction : next_idx

   // Record array, no reset so it can map to block memory
   always_ff @(posedge clk_sys_in) begin
      if (push_in) begin
         mem_q[tail_q] <= push_data_in;
      end
   end

   // Pointers and occupancy; caller never pushes into a full ring
   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         head_q  <= '0;
         tail_q  <= '0;
         count_q <= '0;
      end else if (clr_in) begin
         head_q  <= '0;
         tail_q  <= '0;
         count_q <= '0;
      end else begin
         if (push_in) begin
            tail_q <= next_idx(tail_q);
         end
         if (pop_in) begin
            head_q <= next_idx(head_q);
         end
         if (push_in && !pop_in) begin
            count_q <= mlb_pkg::CNT_W'(count_q + 1'b1);
         end else if (pop_in && !push_in) begin
            count_q <= mlb_pkg::CNT_W'(count_q - 1'b1);
         end
      end
   end

   // Read ports are combinational; the parent registers them
   assign prev_tail  = (tail_q == '0) ?
                       mlb_pkg::CNT_W'(mlb_pkg::CAP - 1) :
                       mlb_pkg::CNT_W'(tail_q - 1'b1);
   assign oldest_out = mem_q[head_q];
   assign newest_out = mem_q[prev_tail];
   assign count_out  = count_q;

endmodule : mlb_log_mem

//--- hdl/mlb_ctrl.sv
`timescale 1ns/1ps
// Behaviour
// - Logging mode normal or bulk, written and read back.
// - Setting changes while busy are dropped and raise the error flag.
// - In bulk mode, initiate or read-start begins bulk logging.
// - Bulk logging appends samples until stop condition or abort.
// - During bulk logging, only exempt accesses work; others raise error.
// - Removal takes count 1..100000, returns oldest records, deletes them.
// - Out-of-range removal count is clamped and raises error.
// - Too few records: nothing returned or deleted, error raised.
// - Removal yields plain record words, no attribute data.
// - Removal and newest-record reads work during measurement.
// - Newest read keeps record; empty gives not-a-number code and error.
// - Record count reads 0..100000.
// - Clear command deletes every record.
// - Depth one of seven sizes, default 1000.
// - Depth rounds up inside range, clamps with error outside.
// - Post share 0..100, default 50, clamped with error.
// - Stop event none, external, level or limit; none needs abort.
// - Bulk state, recorded and remaining counts reported.
module mlb_ctrl (
   input  wire logic                     clk_sys_in,
   input  wire logic                     nrst_in,
   input  wire logic [mlb_pkg::ADDR_W-1:0] addr_in,
   input  wire logic [mlb_pkg::DATA_W-1:0] wdata_in,
   input  wire logic                     wr_in,
   input  wire logic                     rd_in,
   output logic      [mlb_pkg::DATA_W-1:0] rdata_out,
   input  wire logic                     meas_busy_in,
   input  wire logic                     sample_valid_in,
   input  wire logic [mlb_pkg::REC_W-1:0]  sample_in,
   input  wire logic                     ext_trig_in,
   input  wire logic                     level_hit_in,
   input  wire logic                     limit_hit_in,
   output logic                          exec_err_out,
   output logic      [1:0]               bulk_state_out
);

   // -------------------------------------------------------------------
   // Settings and state
   // -------------------------------------------------------------------
   logic                      mode_q;
   logic [mlb_pkg::CNT_W-1:0] depth_q;
   logic [6:0]                post_q;
   logic [1:0]                event_q;
   mlb_pkg::mlb_bulk_type     st_q;
   logic [mlb_pkg::CNT_W-1:0] post_left_q;
   logic [mlb_pkg::CNT_W-1:0] pop_left_q;
   logic                      err_q;
   logic [mlb_pkg::DATA_W-1:0] rdata_q;

   // -------------------------------------------------------------------
   // Combinational terms
   // -------------------------------------------------------------------
   logic                      bulk_run;
   logic                      busy;
   logic                      wr_set;
   logic                      set_err;
   logic                      start;
   logic                      abort;
   logic                      clear;
   logic                      ctrl_err;
   logic                      pop_wr;
   logic                      pop_err;
   logic                      rd_exempt;
   logic                      rd_err;
   logic                      pop_rd;
   logic                      err_set;
   logic                      err_clr;
   logic                      trig_hit;
   logic                      append;
   logic                      push;
   logic                      bulk_drop;
   logic                      mem_pop;
   logic                      mem_clr;
   logic [31:0]               pop_req;
   logic [31:0]               post_req;
   logic [31:0]               depth_req;
   logic [23:0]               post_prod;
   logic [mlb_pkg::CNT_W-1:0] post_tgt;
   logic [mlb_pkg::REC_W-1:0] oldest;
   logic [mlb_pkg::REC_W-1:0] newest;
   logic [mlb_pkg::CNT_W-1:0] count;

   // Next permitted depth at or above the request
   function automatic logic [31:0] depth_round(input logic [31:0] v);
      if (v <= mlb_pkg::DEPTH_1K) begin
         return mlb_pkg::DEPTH_1K;
      end
      if (v <= mlb_pkg::DEPTH_2K) begin
         return mlb_pkg::DEPTH_2K;
      end
      if (v <= mlb_pkg::DEPTH_5K) begin
         return mlb_pkg::DEPTH_5K;
      end
      if (v <= mlb_pkg::DEPTH_10K) begin
         return mlb_pkg::DEPTH_10K;
      end
      if (v <= mlb_pkg::DEPTH_20K) begin
         return mlb_pkg::DEPTH_20K;
      end
      if (v <= mlb_pkg::DEPTH_50K) begin
         return mlb_pkg::DEPTH_50K;
      end
      return mlb_pkg::DEPTH_100K;
   endfunction : depth_round

   // -------------------------------------------------------------------
   // Record store
   // -------------------------------------------------------------------
   mlb_log_mem u_mem (
      .clk_sys_in   (clk_sys_in),
      .nrst_in      (nrst_in),
      .clr_in       (mem_clr),
      .push_in      (push),
      .push_data_in (sample_in),
      .pop_in       (mem_pop),
      .oldest_out   (oldest),
      .newest_out   (newest),
      .count_out    (count)
   );

   // Busy covers trigger wait, measurement and bulk run
   assign bulk_run = (st_q != mlb_pkg::MLB_ST_STOP);
   assign busy     = meas_busy_in | bulk_run;

   // -------------------------------------------------------------------
   // Write decode
   // -------------------------------------------------------------------
   // Any of the four settings registers
   assign wr_set = wr_in & ((addr_in == mlb_pkg::OFS_MODE)  |
                            (addr_in == mlb_pkg::OFS_DEPTH) |
                            (addr_in == mlb_pkg::OFS_POST)  |
                            (addr_in == mlb_pkg::OFS_EVENT));

   // Clamped requests; the compare decides whether an error is due
   assign depth_req = mlb_pkg::clamp(wdata_in, mlb_pkg::DEPTH_1K,
                                     mlb_pkg::DEPTH_100K);
   assign post_req  = mlb_pkg::clamp(wdata_in, 32'h00000000,
                                     mlb_pkg::POST_MAX);
   assign pop_req   = mlb_pkg::clamp(wdata_in, mlb_pkg::POP_MIN,
                                     mlb_pkg::POP_MAX);

   // Busy refusal wins; otherwise clamping raises the flag
   always_comb begin
      set_err = 1'b0;
      if (wr_set && busy) begin
         set_err = 1'b1;
      end else if (wr_in && addr_in == mlb_pkg::OFS_DEPTH) begin
         set_err = (depth_req != wdata_in);
      end else if (wr_in && addr_in == mlb_pkg::OFS_POST) begin
         set_err = (post_req != wdata_in);
      end
   end

   // Control word; during a bulk run only abort is honoured
   always_comb begin
      start    = 1'b0;
      abort    = 1'b0;
      clear    = 1'b0;
      ctrl_err = 1'b0;
      if (wr_in && addr_in == mlb_pkg::OFS_CTRL) begin
         abort = wdata_in[mlb_pkg::CTRL_ABORT_BIT];
         if (bulk_run) begin
            ctrl_err = wdata_in[mlb_pkg::CTRL_INIT_BIT] |
                       wdata_in[mlb_pkg::CTRL_READ_BIT] |
                       wdata_in[mlb_pkg::CTRL_CLEAR_BIT];
         end else begin
            start = (mode_q == mlb_pkg::MODE_BULK) &
                    (wdata_in[mlb_pkg::CTRL_INIT_BIT] |
                     wdata_in[mlb_pkg::CTRL_READ_BIT]);
            clear = wdata_in[mlb_pkg::CTRL_CLEAR_BIT];
         end
      end
   end

   // Removal request: clamp, then check occupancy
   assign pop_wr  = wr_in & (addr_in == mlb_pkg::OFS_POP_CNT) & ~bulk_run;
   assign pop_err = (wr_in & (addr_in == mlb_pkg::OFS_POP_CNT) & bulk_run)
                  | (pop_wr & (pop_req != wdata_in))
                  | (pop_wr & (pop_req > 32'(count)));

   // -------------------------------------------------------------------
   // Read decode
   // -------------------------------------------------------------------
   // Accesses still served while a bulk run is active
   assign rd_exempt = (addr_in == mlb_pkg::OFS_STATE)    |
                      (addr_in == mlb_pkg::OFS_RECORDED) |
                      (addr_in == mlb_pkg::OFS_REMAIN)   |
                      (addr_in == mlb_pkg::OFS_ERR)      |
                      (addr_in == mlb_pkg::OFS_LAST);

   // Removal reads pop one record per strobe while the grant lasts
   assign pop_rd = rd_in & (addr_in == mlb_pkg::OFS_POP_DATA) &
                   ~bulk_run & (pop_left_q != '0) &
                   (count != '0);

   always_comb begin
      rd_err = 1'b0;
      if (rd_in && bulk_run && !rd_exempt) begin
         rd_err = 1'b1;
      end else if (rd_in && addr_in == mlb_pkg::OFS_POP_DATA) begin
         rd_err = ~pop_rd;
      end else if (rd_in && addr_in == mlb_pkg::OFS_LAST) begin
         rd_err = (count == '0);
      end
   end

   // Read data mux, registered so data stand in the next cycle only
   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         rdata_q <= '0;
      end else if (!rd_in || (bulk_run && !rd_exempt)) begin
         rdata_q <= '0;
      end else begin
         case (addr_in)
            mlb_pkg::OFS_MODE:     rdata_q <= 32'(mode_q);
            mlb_pkg::OFS_DEPTH:    rdata_q <= 32'(depth_q);
            mlb_pkg::OFS_POST:     rdata_q <= 32'(post_q);
            mlb_pkg::OFS_EVENT:    rdata_q <= 32'(event_q);
            mlb_pkg::OFS_POP_DATA: begin
               rdata_q <= pop_rd ? oldest : '0;
            end
            mlb_pkg::OFS_LAST: begin
               rdata_q <= (count == '0) ? mlb_pkg::NAN_CODE :
                          newest;
            end
            mlb_pkg::OFS_POINTS:   rdata_q <= 32'(count);
            mlb_pkg::OFS_STATE:    rdata_q <= 32'(st_q);
            mlb_pkg::OFS_RECORDED: begin
               rdata_q <= bulk_run ? 32'(count) : '0;
            end
            mlb_pkg::OFS_REMAIN: begin
               if (!bulk_run || event_q == mlb_pkg::EVT_NONE) begin
                  rdata_q <= '0;
               end else if (st_q == mlb_pkg::MLB_ST_WAIT) begin
                  rdata_q <= 32'(post_tgt);
               end else begin
                  rdata_q <= 32'(post_left_q);
               end
            end
            mlb_pkg::OFS_ERR:      rdata_q <= 32'(err_q);
            default:               rdata_q <= '0;
         endcase
      end
   end

   // -------------------------------------------------------------------
   // Settings registers
   // -------------------------------------------------------------------
   // Held unchanged whenever the write is refused for busy
   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         mode_q  <= mlb_pkg::MODE_NORMAL;
         depth_q <= mlb_pkg::RST_DEPTH;
         post_q  <= mlb_pkg::RST_POST;
         event_q <= mlb_pkg::EVT_NONE;
      end else if (wr_set && !busy) begin
         case (addr_in)
            mlb_pkg::OFS_MODE:  mode_q  <= wdata_in[0];
            mlb_pkg::OFS_DEPTH: begin
               depth_q <= mlb_pkg::CNT_W'(depth_round(depth_req));
            end
            mlb_pkg::OFS_POST:  post_q  <= post_req[6:0];
            mlb_pkg::OFS_EVENT: event_q <= wdata_in[1:0];
            default:            mode_q  <= mode_q;
         endcase
      end
   end

   // -------------------------------------------------------------------
   // Sample append
   // -------------------------------------------------------------------
   // Normal mode logs every sample; bulk mode only while running
   assign append = sample_valid_in &
                   ((mode_q == mlb_pkg::MODE_NORMAL) | bulk_run);

   // Bulk keeps a sliding window of depth records, dropping the oldest
   assign bulk_drop = append & bulk_run & (count >= depth_q);

   // Normal mode drops new samples when full rather than old ones
   assign push = append & (bulk_run |
                 (count != mlb_pkg::CNT_W'(mlb_pkg::CAP)) | pop_rd);

   assign mem_pop = pop_rd | bulk_drop;
   assign mem_clr = clear | start;

   // -------------------------------------------------------------------
   // Removal grant
   // -------------------------------------------------------------------
   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         pop_left_q <= '0;
      end else if (clear || start) begin
         pop_left_q <= '0;
      end else if (pop_wr) begin
         pop_left_q <= (pop_req > 32'(count)) ? '0 :
                       mlb_pkg::CNT_W'(pop_req);
      end else if (pop_rd) begin
         pop_left_q <= mlb_pkg::CNT_W'(pop_left_q - 1'b1);
      end
   end

   // -------------------------------------------------------------------
   // Bulk sequencer
   // -------------------------------------------------------------------
   // Settings are frozen during a run, so the target is stable
   assign post_prod = 24'(depth_q) * 24'(post_q);
   assign post_tgt  = mlb_pkg::CNT_W'(post_prod /
                                      mlb_pkg::PCT_FULL);

   always_comb begin
      case (event_q)
         mlb_pkg::EVT_EXT:   trig_hit = ext_trig_in;
         mlb_pkg::EVT_LEVEL: trig_hit = level_hit_in;
         mlb_pkg::EVT_LIMIT: trig_hit = limit_hit_in;
         default:            trig_hit = 1'b0;
      endcase
   end

   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         st_q        <= mlb_pkg::MLB_ST_STOP;
         post_left_q <= '0;
      end else begin
         case (st_q)
            mlb_pkg::MLB_ST_STOP: begin
               if (start) begin
                  st_q <= mlb_pkg::MLB_ST_WAIT;
               end
            end
            mlb_pkg::MLB_ST_WAIT: begin
               if (abort) begin
                  st_q <= mlb_pkg::MLB_ST_STOP;
               end else if (trig_hit) begin
                  post_left_q <= post_tgt;
                  st_q <= (post_tgt == '0) ? mlb_pkg::MLB_ST_STOP :
                          mlb_pkg::MLB_ST_POST;
               end
            end
            mlb_pkg::MLB_ST_POST: begin
               if (abort) begin
                  st_q        <= mlb_pkg::MLB_ST_STOP;
                  post_left_q <= '0;
               end else if (append) begin
                  post_left_q <= mlb_pkg::CNT_W'(post_left_q - 1'b1);
                  if (post_left_q == mlb_pkg::CNT_W'(1)) begin
                     st_q <= mlb_pkg::MLB_ST_STOP;
                  end
               end
            end
            default: begin
               st_q <= mlb_pkg::MLB_ST_STOP;
            end
         endcase
      end
   end

   // -------------------------------------------------------------------
   // Execution error flag
   // -------------------------------------------------------------------
   // Set wins over a clear in the same cycle so no error is lost
   assign err_set = set_err | ctrl_err | pop_err | rd_err;
   assign err_clr = wr_in & (addr_in == mlb_pkg::OFS_ERR) &
                    wdata_in[mlb_pkg::ERR_BIT];

   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         err_q <= 1'b0;
      end else begin
         err_q <= err_set | (err_q & ~err_clr);
      end
   end

   // -------------------------------------------------------------------
   // Outputs
   // -------------------------------------------------------------------
   assign rdata_out      = rdata_q;
   assign exec_err_out   = err_q;
   assign bulk_state_out = st_q;

endmodule : mlb_ctrl

//--- verification/mlb_ctrl_properties.sv
`timescale 1ns/1ps
// Watches the register port and bulk status of the controller
module mlb_ctrl_chk (
   input wire logic        clk_sys_in,
   input wire logic        nrst_in,
   input wire logic [3:0]  addr_in,
   input wire logic [31:0] wdata_in,
   input wire logic        wr_in,
   input wire logic        rd_in,
   input wire logic        meas_busy_in,
   input wire logic        sample_valid_in,
   input wire logic [31:0] rdata_out,
   input wire logic        exec_err_out,
   input wire logic [1:0]  bulk_state_out
);
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (!nrst_in);
   // Abort strobe on the control word
   sequence s_abort;
      wr_in && addr_in == 4'h4 && wdata_in[2];
   endsequence
   idle_zero_a:
      assert property (!rd_in |=> rdata_out == 32'h0) else $error("stray data");
   err_keep_a:
      assert property (exec_err_out && !(wr_in && addr_in == 4'hc && wdata_in[0])
         |=> exec_err_out) else $error("error flag lost");
   busy_refuse_a:
      assert property (wr_in && addr_in <= 4'h3 && meas_busy_in |=> exec_err_out)
         else $error("busy write not flagged");
   bulk_refuse_a:
      assert property (rd_in && addr_in == 4'h8 && bulk_state_out != 2'h0
         |=> exec_err_out && rdata_out == 32'h0) else $error("bulk read taken");
   abort_stop_a:
      assert property (s_abort ##0 bulk_state_out != 2'h0 |=> bulk_state_out == 2'h0)
         else $error("abort ignored");
   no_jump_a:
      assert property (bulk_state_out == 2'h0 |=> bulk_state_out != 2'h2)
         else $error("stop jumped to post");
   post_hold_a:
      assert property (bulk_state_out == 2'h2 && !sample_valid_in && !wr_in
         |=> bulk_state_out == 2'h2) else $error("post left early");
   err_read_a:
      assert property (rd_in && addr_in == 4'hc
         |=> rdata_out[0] == $past(exec_err_out)) else $error("error read wrong");
endmodule : mlb_ctrl_chk
bind mlb_ctrl mlb_ctrl_chk i_chk (.*);

//--- verification/mlb_host_model.sv
`timescale 1ns/1ps
// Host side of the register port, one strobe per access
module mlb_host_model (
   input  wire logic        clk_sys_in,
   output logic [3:0]       addr_out,
   output logic [31:0]      wdata_out,
   output logic             wr_out,
   output logic             rd_out,
   input  wire logic [31:0] rdata_in
);
   // Bus idles low from time zero
   initial begin
      addr_out = 4'h0;
      wdata_out = 32'h0;
      wr_out = 1'b0;
      rd_out = 1'b0;
   end
   task wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_sys_in);
      addr_out <= a;
      wdata_out <= d;
      wr_out <= 1'b1;
      @(posedge clk_sys_in);
      wr_out <= 1'b0;
   endtask : wr
   // Data is taken just after the edge, clear of the update race
   task rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge clk_sys_in);
      addr_out <= a;
      rd_out <= 1'b1;
      @(posedge clk_sys_in);
      rd_out <= 1'b0;
      #1 d = rdata_in;
   endtask : rd
endmodule : mlb_host_model

//--- verification/measurement_log_buffer_control_bench.sv
`timescale 1ns/1ps
module measurement_log_buffer_control_bench;
   logic        clk  = 1'b0;
   logic        nrst = 1'b0;
   logic        busy = 1'b0;
   logic        sv   = 1'b0;
   logic        trig = 1'b0;
   logic [31:0] smp  = 32'h0;
   logic [3:0]  addr;
   logic [31:0] wdata;
   logic [31:0] rdata;
   logic        wr;
   logic        rd;
   logic        err;
   logic [1:0]  st;
   int          err_count = 0;
   int          tests_run = 0;
   // 50 MHz system clock
   always #10 clk = ~clk;
   mlb_host_model i_host (.clk_sys_in(clk), .addr_out(addr), .wdata_out(wdata),
      .wr_out(wr), .rd_out(rd), .rdata_in(rdata));
   mlb_ctrl i_mlb_ctrl (.clk_sys_in(clk), .nrst_in(nrst), .addr_in(addr),
      .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata),
      .meas_busy_in(busy), .sample_valid_in(sv), .sample_in(smp),
      .ext_trig_in(trig), .level_hit_in(trig), .limit_hit_in(trig),
      .exec_err_out(err), .bulk_state_out(st));
   task chk(input logic [31:0] g, input logic [31:0] e);
      tests_run++;
      if (g !== e) begin
         err_count++;
         $display("wrong value at %0t got %h exp %h", $time, g, e);
      end
   endtask : chk
   task rc(input logic [3:0] a, input logic [31:0] e);
      logic [31:0] d;
      i_host.rd(a, d);
      chk(d, e);
   endtask : rc
   // Flag is judged a cycle late, then cleared for the next step
   task ec(input logic e);
      @(posedge clk);
      #1 chk({31'h0, err}, {31'h0, e});
      i_host.wr(4'hc, 32'h1);
   endtask : ec
   // Records carry their own index, so order is visible
   task push(input int n, input int b);
      for (int i = 0; i < n; i++) begin
         @(posedge clk);
         sv <= 1'b1;
         smp <= 32'(b + i);
      end
      @(posedge clk);
      sv <= 1'b0;
   endtask : push
   task t_setup;
      rc(4'h0, 32'h0);
      rc(4'h1, mlb_pkg::DEPTH_1K);
      rc(4'h2, 32'h32);
      rc(4'h8, 32'h0);
      rc(4'h7, mlb_pkg::NAN_CODE);
      ec(1'b1);
      i_host.wr(4'h1, 32'h5dc);
      rc(4'h1, mlb_pkg::DEPTH_2K);
      ec(1'b0);
      i_host.wr(4'h1, 32'h30d41);
      rc(4'h1, mlb_pkg::DEPTH_100K);
      ec(1'b1);
      i_host.wr(4'h2, 32'h96);
      rc(4'h2, mlb_pkg::POST_MAX);
      ec(1'b1);
      i_host.wr(4'h1, mlb_pkg::DEPTH_1K);
      busy <= 1'b1;
      i_host.wr(4'h0, 32'h1);
      ec(1'b1);
      rc(4'h0, 32'h0);
      $display("setup test done");
   endtask : t_setup
   task t_pop;
      push(3, 1);
      rc(4'h8, 32'h3);
      i_host.wr(4'h5, 32'h5);
      rc(4'h6, 32'h0);
      rc(4'h8, 32'h3);
      i_host.wr(4'h5, 32'h2);
      rc(4'h6, 32'h1);
      rc(4'h6, 32'h2);
      rc(4'h8, 32'h1);
      rc(4'h7, 32'h3);
      rc(4'h8, 32'h1);
      ec(1'b1);
      i_host.wr(4'h5, 32'h0);
      ec(1'b1);
      rc(4'h6, 32'h3);
      busy <= 1'b0;
      push(2, 4);
      i_host.wr(4'h4, 32'h8);
      rc(4'h8, 32'h0);
      $display("pop test done");
   endtask : t_pop
   task t_bulk;
      i_host.wr(4'h0, 32'h1);
      i_host.wr(4'h2, 32'h1);
      i_host.wr(4'h3, 32'h1);
      i_host.wr(4'h4, 32'h1);
      rc(4'h9, 32'h1);
      chk(32'(st), 32'h1);
      rc(4'h8, 32'h0);
      ec(1'b1);
      push(5, 1);
      rc(4'ha, 32'h5);
      rc(4'hb, 32'ha);
      @(posedge clk);
      trig <= 1'b1;
      @(posedge clk);
      trig <= 1'b0;
      push(9, 6);
      rc(4'hb, 32'h1);
      push(1, 15);
      rc(4'h9, 32'h0);
      rc(4'ha, 32'h0);
      rc(4'h8, 32'hf);
      i_host.wr(4'h3, 32'h0);
      i_host.wr(4'h4, 32'h2);
      push(20, 1);
      @(posedge clk);
      trig <= 1'b1;
      @(posedge clk);
      trig <= 1'b0;
      rc(4'h9, 32'h1);
      rc(4'hb, 32'h0);
      i_host.wr(4'h4, 32'h4);
      rc(4'h9, 32'h0);
      $display("bulk test done");
   endtask : t_bulk
   task close_out;
      $display("checks %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : close_out
   // Main sequence after a 16 cycle reset
   initial begin
      repeat (16) @(posedge clk);
      nrst <= 1'b1;
      t_setup();
      t_pop();
      t_bulk();
      close_out();
   end
   // Watchdog well past the expected run length
   initial begin
      repeat (5000) @(posedge clk);
      err_count++;
      close_out();
   end
endmodule : measurement_log_buffer_control_bench
